// ### rtl/cfg_set_pkg.sv
// Types shared by the configuration set store
package cfg_set_pkg;

    // Parameters that form one configuration set
    typedef struct packed {
        logic [15:0] gain;
        logic [15:0] exposure;
        logic [1:0]  auto_mode;
        logic [7:0]  white_bal;
    } param_set_type;

    // Register port request
    typedef struct packed {
        logic [5:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

    typedef enum logic [1:0] {
        XFER_IDLE,
        XFER_SAVE,
        XFER_LOAD
    } xfer_state_type;

endpackage

// ### rtl/cfg_set_regs.svh
// Register offsets, field positions, selector codes, factory set contents and timing counts of the configuration set store
`ifndef CFG_SET_REGS_SVH
`define CFG_SET_REGS_SVH

// ****************************************************************
// Register offsets (word index on the plain register port)
// ****************************************************************
`define OFS_VENDOR_ID        6'h00
`define OFS_MODEL_ID         6'h01
`define OFS_MFR_INFO         6'h02
`define OFS_DEVICE_VERSION   6'h03
`define OFS_FW_VERSION       6'h04
`define OFS_SERIAL           6'h05
`define OFS_USER_NAME        6'h06
`define OFS_SCAN_TYPE        6'h07
`define OFS_SENSOR_WIDTH     6'h08
`define OFS_SENSOR_HEIGHT    6'h09
`define OFS_MAX_WIDTH        6'h0A
`define OFS_MAX_HEIGHT       6'h0B
`define OFS_TEMP_SELECT      6'h0C
`define OFS_TEMP_READING     6'h0D
`define OFS_SLOT_SELECT      6'h0E
`define OFS_FACTORY_SELECT   6'h0F
`define OFS_STARTUP_SELECT   6'h10
`define OFS_COMMAND          6'h11
`define OFS_STATUS           6'h12
`define OFS_GAIN             6'h13
`define OFS_EXPOSURE         6'h14
`define OFS_AUTO_CTRL        6'h15
`define OFS_LUT_VALUE        6'h16

// ****************************************************************
// Field positions
// ****************************************************************
`define CMD_SAVE_BIT         0
`define CMD_LOAD_BIT         1
`define STS_BUSY_BIT         0
`define STS_STARTUP_BIT      1
`define STS_REFUSED_BIT      2

// ****************************************************************
// Selector codes
// ****************************************************************
`define SLOT_DEFAULT         2'h0
`define SLOT_USER1           2'h1
`define SLOT_USER3           2'h3
`define TEMP_SRC_BOARD       2'h0
`define FACTORY_STANDARD     2'h0

// ****************************************************************
// Factory set contents
// ****************************************************************
`define GAIN_LOW             16'h0000
`define GAIN_PLUS_6DB        16'h0200
`define GAIN_COLOR           16'h0040
`define EXPOSURE_STD         16'h1000
`define EXPOSURE_COLOR       16'h0800
`define AUTO_OFF             2'h0
`define AUTO_BOTH_CONT       2'h3
`define WB_NEUTRAL           8'h80
`define WB_DAYLIGHT          8'hA0

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS        100
`define NV_XFER_TIME_NS      400
`define NV_XFER_CYCLES       ((`NV_XFER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtl/config_set_manager.sv
// Device information registers and configuration set store with save, load and startup load
`include "cfg_set_regs.svh"

// Function
// - Information values are read-only; only the user-assigned name is writable.
// - Serial number is readable at any time, never writable.
// - Board temperature in degrees centigrade, selected by the temperature source selector.
// - Maximum area width and height are read-only, separate from sensor size.
// - Active set is volatile: reset discards it.
// - Every host parameter write while no save, load or startup load is in progress updates the active set and drives operation.
// - Four factory sets are fixed, survive reset and reject modification.
// - High-gain set equals standard set but gain is plus 6 dB.
// - Auto-functions set runs gain and exposure auto continuously, gain kept minimal.
// - Default factory choice survives reset.
// - Default set may be copied into active set on host request.
// - At reset the startup set, default or user set, loads into active set.
// - Three user slots survive reset.
// - Save copies active parameters except lookup table value, which reset clears.
// - Save fully replaces the previous slot contents.
// - Load or factory selection change only while acquisition is idle.
module config_set_manager
    import cfg_set_pkg::*;
#(
    parameter logic [31:0] VENDOR_CODE    = 32'h0000_1234,   // arbitrary value
    parameter logic [31:0] MODEL_CODE     = 32'h0000_0042,   // arbitrary value
    parameter logic [31:0] MFR_INFO       = 32'h0000_0000,
    parameter logic [31:0] DEVICE_VERSION = 32'h0000_0001,
    parameter logic [31:0] FW_VERSION     = 32'h0000_0001,
    parameter logic [31:0] SERIAL_NUMBER  = 32'h0012_3456,   // arbitrary value
    parameter logic [31:0] SCAN_TYPE      = 32'h0000_0000,
    parameter logic [15:0] SENSOR_WIDTH   = 16'h0300,
    parameter logic [15:0] SENSOR_HEIGHT  = 16'h0200,
    parameter logic [15:0] MAX_WIDTH      = 16'h02F0,
    parameter logic [15:0] MAX_HEIGHT     = 16'h01E0
) (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    // Register port
    input  wire cfg_set_pkg::reg_req_type  reg_req,
    output      logic [31:0]               reg_rdata,
    // Acquisition status and sensor
    input  wire logic                      acq_running,
    input  wire logic                      acq_pending,
    input  wire logic [15:0]               board_temp_raw,
    // Nonvolatile slot store, kept outside the reset domain
    input  wire cfg_set_pkg::param_set_type nv_user1,
    input  wire cfg_set_pkg::param_set_type nv_user2,
    input  wire cfg_set_pkg::param_set_type nv_user3,
    input  wire logic [1:0]                nv_factory_choice,
    input  wire logic [1:0]                nv_startup_choice,
    output      logic                      nv_wr,
    output      logic [1:0]                nv_wr_slot,
    output      cfg_set_pkg::param_set_type nv_wr_data,
    output      logic                      nv_wr_factory,
    output      logic                      nv_wr_startup,
    output      logic [1:0]                nv_wr_choice,
    // Active set driving the camera
    output      cfg_set_pkg::param_set_type active_set,
    output      logic [31:0]               lut_value
);
    import cfg_set_pkg::*;

    localparam int XFER_CYC = `NV_XFER_CYCLES;

    // ****************************************************************
    // Factory sets, constant logic
    // ****************************************************************
    param_set_type factory_tbl [4];
    assign factory_tbl[0] = '{`GAIN_LOW, `EXPOSURE_STD, `AUTO_OFF, `WB_NEUTRAL};
    assign factory_tbl[1] = '{`GAIN_PLUS_6DB, `EXPOSURE_STD, `AUTO_OFF, `WB_NEUTRAL};
    assign factory_tbl[2] = '{`GAIN_LOW, `EXPOSURE_STD, `AUTO_BOTH_CONT, `WB_NEUTRAL};
    assign factory_tbl[3] = '{`GAIN_COLOR, `EXPOSURE_COLOR, `AUTO_OFF, `WB_DAYLIGHT};

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [1:0] run_s_r;
    logic [1:0] pend_s_r;
    logic       idle;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            run_s_r  <= 2'h0;
            pend_s_r <= 2'h0;
        end else begin
            run_s_r  <= {run_s_r[0], acq_running};
            pend_s_r <= {pend_s_r[0], acq_pending};
        end
    end
    assign idle = !run_s_r[1] && !pend_s_r[1];

    // ****************************************************************
    // Host registers
    // ****************************************************************
    logic [31:0]   user_assigned_name_r;
    logic [1:0]    temperature_source_select_r;
    logic [1:0]    set_slot_select_r;
    logic [15:0]   temp_r;
    logic          wr_hit;
    param_set_type source_set;
    logic [1:0]    factory_sel;
    logic [1:0]    startup_sel;

    assign factory_sel = nv_factory_choice;
    assign startup_sel = nv_startup_choice;
    assign wr_hit      = reg_req.wr;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            user_assigned_name_r        <= 32'h0000_0000;
            temperature_source_select_r <= `TEMP_SRC_BOARD;
            set_slot_select_r           <= `SLOT_DEFAULT;
        end else if (wr_hit) begin
            case (reg_req.addr)
                `OFS_USER_NAME:   user_assigned_name_r <= reg_req.wdata;
                `OFS_TEMP_SELECT: temperature_source_select_r <= reg_req.wdata[1:0];
                `OFS_SLOT_SELECT: set_slot_select_r <= reg_req.wdata[1:0];
                default: ;
            endcase
        end
    end

    // Board temperature sampled each cycle, two-stage for the pin domain
    logic [15:0] temp_s_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            temp_s_r <= 16'h0000;
            temp_r   <= 16'h0000;
        end else begin
            temp_s_r <= board_temp_raw;
            temp_r   <= temp_s_r;
        end
    end

    // ****************************************************************
    // Transfer sequencer
    // ****************************************************************
    xfer_state_type state_r;
    logic [3:0]     cnt_r;
    logic           startup_done_r;
    logic           refused_r;
    logic           save_req;
    logic           load_req;
    logic           cmd_wr;
    logic [1:0]     xfer_slot_r;

    assign cmd_wr   = wr_hit && reg_req.addr == `OFS_COMMAND;
    assign save_req = cmd_wr && reg_req.wdata[`CMD_SAVE_BIT] && set_slot_select_r != `SLOT_DEFAULT;
    assign load_req = cmd_wr && reg_req.wdata[`CMD_LOAD_BIT] && idle;

    always_comb begin
        // Slot latched at command time so a selector write mid-transfer cannot redirect it
        case (xfer_slot_r)
            2'h1:    source_set = nv_user1;
            2'h2:    source_set = nv_user2;
            2'h3:    source_set = nv_user3;
            default: source_set = factory_tbl[factory_sel];
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= XFER_IDLE;
            cnt_r   <= 4'h0;
            xfer_slot_r <= `SLOT_DEFAULT;
        end else begin
            case (state_r)
                XFER_IDLE: begin
                    cnt_r <= 4'h0;
                    xfer_slot_r <= set_slot_select_r;
                    if (save_req && startup_done_r) begin
                        state_r <= XFER_SAVE;
                    end else if (load_req && startup_done_r) begin
                        state_r <= XFER_LOAD;
                    end
                end
                XFER_SAVE, XFER_LOAD: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'(XFER_CYC - 1)) begin
                        state_r <= XFER_IDLE;
                    end
                end
                default: state_r <= XFER_IDLE;
            endcase
        end
    end

    logic xfer_end;
    assign xfer_end = state_r != XFER_IDLE && cnt_r == 4'(XFER_CYC - 1);

    // Refused command flag: set wins over clear by a fresh command
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            refused_r <= 1'b0;
        end else if (cmd_wr) begin
            refused_r <= !(save_req || load_req) || state_r != XFER_IDLE;
        end
    end

    // ****************************************************************
    // Active set
    // ****************************************************************
    param_set_type startup_set;
    always_comb begin
        case (startup_sel)
            2'h1:    startup_set = nv_user1;
            2'h2:    startup_set = nv_user2;
            2'h3:    startup_set = nv_user3;
            default: startup_set = factory_tbl[factory_sel];
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            active_set     <= '0;
            startup_done_r <= 1'b0;
        end else if (!startup_done_r) begin
            active_set     <= startup_set;
            startup_done_r <= 1'b1;
        end else if (state_r == XFER_LOAD && xfer_end) begin
            active_set <= source_set;
        end else if (wr_hit && state_r == XFER_IDLE) begin
            case (reg_req.addr)
                `OFS_GAIN:      active_set.gain      <= reg_req.wdata[15:0];
                `OFS_EXPOSURE:  active_set.exposure  <= reg_req.wdata[15:0];
                `OFS_AUTO_CTRL: begin
                    active_set.auto_mode <= reg_req.wdata[1:0];
                    active_set.white_bal <= reg_req.wdata[15:8];
                end
                default: ;
            endcase
        end
    end

    // Lookup value is volatile and never saved
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lut_value <= 32'h0000_0000;
        end else if (wr_hit && reg_req.addr == `OFS_LUT_VALUE) begin
            lut_value <= reg_req.wdata;
        end
    end

    // ****************************************************************
    // Nonvolatile write strobes
    // ****************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            nv_wr         <= 1'b0;
            nv_wr_slot    <= `SLOT_DEFAULT;
            nv_wr_data    <= '0;
            nv_wr_factory <= 1'b0;
            nv_wr_startup <= 1'b0;
            nv_wr_choice  <= `FACTORY_STANDARD;
        end else begin
            nv_wr         <= state_r == XFER_SAVE && xfer_end;
            nv_wr_factory <= wr_hit && reg_req.addr == `OFS_FACTORY_SELECT && idle;
            nv_wr_startup <= wr_hit && reg_req.addr == `OFS_STARTUP_SELECT;
            if (wr_hit) begin
                nv_wr_choice <= reg_req.wdata[1:0];
            end
            if (state_r == XFER_SAVE && xfer_end) begin
                nv_wr_slot <= xfer_slot_r;
                nv_wr_data <= active_set;
            end
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                `OFS_VENDOR_ID:      reg_rdata <= VENDOR_CODE;
                `OFS_MODEL_ID:       reg_rdata <= MODEL_CODE;
                `OFS_MFR_INFO:       reg_rdata <= MFR_INFO;
                `OFS_DEVICE_VERSION: reg_rdata <= DEVICE_VERSION;
                `OFS_FW_VERSION:     reg_rdata <= FW_VERSION;
                `OFS_SERIAL:         reg_rdata <= SERIAL_NUMBER;
                `OFS_USER_NAME:      reg_rdata <= user_assigned_name_r;
                `OFS_SCAN_TYPE:      reg_rdata <= SCAN_TYPE;
                `OFS_SENSOR_WIDTH:   reg_rdata <= {16'h0000, SENSOR_WIDTH};
                `OFS_SENSOR_HEIGHT:  reg_rdata <= {16'h0000, SENSOR_HEIGHT};
                `OFS_MAX_WIDTH:      reg_rdata <= {16'h0000, MAX_WIDTH};
                `OFS_MAX_HEIGHT:     reg_rdata <= {16'h0000, MAX_HEIGHT};
                `OFS_TEMP_SELECT:    reg_rdata <= {30'h0, temperature_source_select_r};
                `OFS_TEMP_READING:   reg_rdata <= (temperature_source_select_r == `TEMP_SRC_BOARD) ?
                                                  {16'h0000, temp_r} : 32'h0000_0000;
                `OFS_SLOT_SELECT:    reg_rdata <= {30'h0, set_slot_select_r};
                `OFS_FACTORY_SELECT: reg_rdata <= {30'h0, factory_sel};
                `OFS_STARTUP_SELECT: reg_rdata <= {30'h0, startup_sel};
                `OFS_COMMAND:        reg_rdata <= {30'h0, state_r == XFER_LOAD, state_r == XFER_SAVE};
                `OFS_STATUS:         reg_rdata <= {29'h0, refused_r, startup_done_r, state_r != XFER_IDLE};
                `OFS_GAIN:           reg_rdata <= {16'h0000, active_set.gain};
                `OFS_EXPOSURE:       reg_rdata <= {16'h0000, active_set.exposure};
                `OFS_AUTO_CTRL:      reg_rdata <= {16'h0000, active_set.white_bal, 6'h00, active_set.auto_mode};
                `OFS_LUT_VALUE:      reg_rdata <= lut_value;
                default:             reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_STARTUP_LOAD: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(startup_done_r) |-> active_set == $past(startup_set))
        else $error("startup set not loaded");
    AST_SAVE_WRITES: assert property (@(posedge clock) disable iff (sys_rst)
        (state_r == XFER_SAVE && xfer_end) |=> nv_wr && nv_wr_data == $past(active_set))
        else $error("save did not write active set");
    AST_CMD_CLEARS: assert property (@(posedge clock) disable iff (sys_rst)
        (state_r == XFER_IDLE ##1 state_r != XFER_IDLE) |-> ##4 state_r == XFER_IDLE)
        else $error("command did not clear in time");
    AST_LOAD_IDLE: assert property (@(posedge clock) disable iff (sys_rst)
        (state_r == XFER_IDLE ##1 state_r == XFER_LOAD) |-> $past(idle))
        else $error("load started while acquiring");
    AST_FACTORY_IDLE: assert property (@(posedge clock) disable iff (sys_rst)
        nv_wr_factory |-> $past(idle))
        else $error("factory choice changed while acquiring");
    AST_SAVE_SLOT: assert property (@(posedge clock) disable iff (sys_rst)
        nv_wr |-> nv_wr_slot != `SLOT_DEFAULT)
        else $error("save into default slot");
    AST_GAIN_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
        (startup_done_r && wr_hit && reg_req.addr == `OFS_GAIN && state_r == XFER_IDLE)
        |=> active_set.gain == $past(reg_req.wdata[15:0]))
        else $error("gain write lost");
    AST_SERIAL_READ: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == `OFS_SERIAL) |=> reg_rdata == SERIAL_NUMBER)
        else $error("serial number wrong");
    AST_LOAD_APPLY: assert property (@(posedge clock) disable iff (sys_rst)
        (state_r == XFER_LOAD && xfer_end) |=> active_set == $past(source_set))
        else $error("load did not apply set");

endmodule

// ### tb/config_set_manager_tb.sv
// Self-checking bench for the configuration set store
`include "cfg_set_regs.svh"
module config_set_manager_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cfg_set_pkg::*;

    localparam logic [31:0] SER = 32'h0000_5A5A;   // arbitrary value
    localparam logic [15:0] MW  = 16'h0280;
    localparam logic [15:0] MH  = 16'h01A0;
    localparam param_set_type A  = '{16'h0155, 16'h0777, 2'h2, 8'h5A};
    localparam param_set_type U1 = '{16'h0111, 16'h0222, 2'h1, 8'h33};
    localparam param_set_type U3 = '{16'h0311, 16'h0322, 2'h3, 8'h44};

    logic          clock, sys_rst, acq_running, acq_pending, nv_wr, nv_wr_factory, nv_wr_startup, seen;
    reg_req_type   reg_req;
    logic [31:0]   reg_rdata, lut_value, rdv;
    logic [15:0]   board_temp_raw;
    logic [1:0]    nv_factory_choice, nv_startup_choice, nv_wr_slot, nv_wr_choice;
    param_set_type nv_user1, nv_user2, nv_user3, nv_wr_data, active_set;
    int            n_errors, checks, cyc;

    config_set_manager #(.SERIAL_NUMBER(SER), .MAX_WIDTH(MW), .MAX_HEIGHT(MH)) config_set_manager_inst (
        .clock(clock), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .acq_running(acq_running), .acq_pending(acq_pending), .board_temp_raw(board_temp_raw),
        .nv_user1(nv_user1), .nv_user2(nv_user2), .nv_user3(nv_user3),
        .nv_factory_choice(nv_factory_choice), .nv_startup_choice(nv_startup_choice),
        .nv_wr(nv_wr), .nv_wr_slot(nv_wr_slot), .nv_wr_data(nv_wr_data), .nv_wr_factory(nv_wr_factory),
        .nv_wr_startup(nv_wr_startup), .nv_wr_choice(nv_wr_choice), .active_set(active_set),
        .lut_value(lut_value));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        reg_req.rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask

    task automatic wait_idle();
        repeat (20) begin
            rd(`OFS_STATUS);
            if (rdv[`STS_BUSY_BIT] === 1'b0) break;
        end
    endtask

    task automatic wait_nvwr();
        seen = 1'b0;
        repeat (12) begin
            @(posedge clock);
            #1;
            if (nv_wr === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
    endtask

    task automatic do_reset();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_info();
        wr(`OFS_SERIAL, 32'hFFFF_FFFF);
        rd(`OFS_SERIAL);
        chk("serial", rdv, SER);
        wr(`OFS_MAX_WIDTH, 32'h0);
        rd(`OFS_MAX_WIDTH);
        chk("max_w", rdv, {16'h0, MW});
        rd(`OFS_MAX_HEIGHT);
        chk("max_h", rdv, {16'h0, MH});
        wr(`OFS_USER_NAME, 32'h1234_5678);
        rd(`OFS_USER_NAME);
        chk("user_name", rdv, 32'h1234_5678);
        rd(6'h3F);
        chk("unmapped", rdv, 32'h0);
        wr(`OFS_TEMP_SELECT, {30'h0, `TEMP_SRC_BOARD});
        rd(`OFS_TEMP_READING);
        chk("temp", rdv, 32'h19);
        $display("test info done");
    endtask

    task automatic t_save();
        wr(`OFS_GAIN, {16'h0, A.gain});
        wr(`OFS_EXPOSURE, {16'h0, A.exposure});
        wr(`OFS_AUTO_CTRL, {16'h0, A.white_bal, 6'h0, A.auto_mode});
        wr(`OFS_LUT_VALUE, 32'hCAFE_F00D);
        @(posedge clock);
        #1;
        chk("active", active_set, A);
        chk("lut", lut_value, 32'hCAFE_F00D);
        wr(`OFS_SLOT_SELECT, 32'h2);
        wr(`OFS_COMMAND, 32'h1);
        wr(`OFS_SLOT_SELECT, {30'h0, `SLOT_DEFAULT});
        wait_nvwr();
        chk("nv_wr", seen, 1'b1);
        chk("nv_slot", nv_wr_slot, 2'h2);
        chk("nv_data", nv_wr_data, A);
        wait_idle();
        rd(`OFS_COMMAND);
        chk("cmd_clear", rdv[1:0], 2'h0);
        wr(`OFS_SLOT_SELECT, {30'h0, `SLOT_DEFAULT});
        wr(`OFS_COMMAND, 32'h1);
        wait_nvwr();
        chk("save_slot0", seen, 1'b0);
        rd(`OFS_STATUS);
        chk("refused", rdv[`STS_REFUSED_BIT], 1'b1);
        $display("test save done");
    endtask

    task automatic t_load();
        logic [15:0] gains [4];
        logic [1:0]  autos [4];
        gains = '{`GAIN_LOW, `GAIN_PLUS_6DB, `GAIN_LOW, `GAIN_COLOR};
        autos = '{`AUTO_OFF, `AUTO_OFF, `AUTO_BOTH_CONT, `AUTO_OFF};
        acq_running <= 1'b1;
        repeat (3) @(posedge clock);
        wr(`OFS_SLOT_SELECT, {30'h0, `SLOT_USER1});
        wr(`OFS_COMMAND, 32'h2);
        wait_idle();
        rd(`OFS_STATUS);
        chk("load_busy_ref", rdv[`STS_REFUSED_BIT], 1'b1);
        chk("load_busy_act", active_set, A);
        acq_running <= 1'b0;
        acq_pending <= 1'b1;
        repeat (3) @(posedge clock);
        wr(`OFS_FACTORY_SELECT, 32'h1);
        #1;
        chk("fac_busy", nv_wr_factory, 1'b0);
        acq_pending <= 1'b0;
        repeat (3) @(posedge clock);
        wr(`OFS_FACTORY_SELECT, 32'h2);
        #1;
        chk("fac_wr", nv_wr_factory, 1'b1);
        chk("fac_choice", nv_wr_choice, 2'h2);
        wr(`OFS_STARTUP_SELECT, 32'h3);
        #1;
        chk("start_wr", nv_wr_startup, 1'b1);
        chk("start_choice", nv_wr_choice, 2'h3);
        wr(`OFS_COMMAND, 32'h2);
        wait_idle();
        chk("load_user1", active_set, U1);
        for (int k = 0; k < 4; k++) begin
            nv_factory_choice <= 2'(k);
            wr(`OFS_SLOT_SELECT, {30'h0, `SLOT_DEFAULT});
            wr(`OFS_COMMAND, 32'h2);
            wait_idle();
            chk("fac_gain", active_set.gain, gains[k]);
            chk("fac_auto", active_set.auto_mode, autos[k]);
        end
        $display("test load done");
    endtask

    task automatic t_start();
        nv_startup_choice <= 2'h3;
        do_reset();
        chk("startup_u3", active_set, U3);
        chk("lut_lost", lut_value, 32'h0);
        nv_startup_choice <= 2'h0;
        nv_factory_choice <= 2'h1;
        do_reset();
        chk("startup_def", active_set.gain, `GAIN_PLUS_6DB);
        chk("startup_exp", active_set.exposure, `EXPOSURE_STD);
        $display("test startup done");
    endtask

    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        sys_rst = 1'b1;
        reg_req = '0;
        acq_running = 1'b0;
        acq_pending = 1'b0;
        board_temp_raw = 16'h0019;
        nv_user1 = U1;
        nv_user2 = '0;
        nv_user3 = U3;
        nv_factory_choice = `FACTORY_STANDARD;
        nv_startup_choice = 2'h0;
        n_errors = 0;
        checks = 0;
        cyc = 0;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
        t_info();
        t_save();
        t_load();
        t_start();
        results();
    end
endmodule
